// ==== src/ebpc_regs.svh ====
// Register offsets, field positions, reset values for the pin configuration block.
// Assumes inclusion by design files that need the register layout.
`ifndef EBPC_REGS_SVH
`define EBPC_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define EBPC_CFG_OFS 12'h000
`define EBPC_CTRL_OFS 12'h004
`define EBPC_STAT_OFS 12'h008

// ----------------------------------------
// Field positions of the configuration word
// ----------------------------------------
`define EBPC_RDY_INV_LSB 28
`define EBPC_RDY_CLAIM_LSB 24
`define EBPC_LEVEL_BIT 17
`define EBPC_RP_BIT 16
`define EBPC_WE_BIT 13
`define EBPC_OE_BIT 12
`define EBPC_BS_LSB 8
`define EBPC_CS_LSB 4
`define EBPC_DATA_LSB 0

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define EBPC_CFG_RESET 32'h0000_0000
`define EBPC_CFG_MASK 32'h7703_33f3
`define EBPC_CTRL_RESET 32'h0000_0000

`endif

// ==== src/ebpc_pkg.sv ====
// Types shared by the pin configuration block.
// Assumes the register header supplies the numeric layout.
package ebpc_pkg;

  typedef struct packed {
    logic [2:0] ready_invert;
    logic [2:0] ready_pin_claim;
    logic ready_level_sense;
    logic reset_powerdown_pin_claim;
    logic write_strobe_pin_claim;
    logic output_strobe_pin_claim;
    logic [1:0] byte_select_pin_claim;
    logic [3:0] chip_select_pin_claim;
    logic [1:0] data_pin_claim;
  } ebpc_cfg_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ebpc_apb_req_type;

  typedef struct packed {
    logic [2:0] ready;
    logic reset_powerdown;
    logic write_strobe;
    logic output_strobe;
    logic [1:0] byte_select;
    logic [3:0] chip_select;
    logic [1:0] data;
  } ebpc_claim_type;

endpackage

// ==== src/ebpc_sync2.sv ====
// Two-flop synchroniser for one pin input.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/1ps
module ebpc_sync2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule

// ==== src/ebpc_ready_cond.sv ====
// Conditions one ready input: optional inversion, then edge or level detection.
// Assumes the pin has already been synchronised to clk_i.
`timescale 1ns/1ps
module ebpc_ready_cond (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic invert_i,
  input wire logic level_i,
  output logic ready_o
);
  logic prev_q;
  logic prev_d;
  logic polar;

  always_comb begin
    polar = pin_i ^ invert_i;
    prev_d = polar;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // Edge mode flags one cycle on a rising of the polarity-corrected pin
  assign ready_o = level_i ? polar : (polar & ~prev_q);
endmodule

// ==== src/ebpc_top.sv ====
// Pin configuration for the external memory bus unit, with an APB slave.
// Assumes a single 250 MHz clock, APB master on the same clock, pins asynchronous.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ebpc_regs.svh"

// Functional notes
// - Each ready input is inverted before use when its invert bit is set.
// - Ready claim bit set hands that pin to the bus unit, else general use.
// - Level sense bit 1 selects level detection, 0 edge detection, all readies.
// - Reset/power-down claim bit 1 gives that active-low pin to the bus unit.
// - Bus-mode override set ignores the whole configuration; all pins stay general.
// - Unassigned bit positions ignore writes and read as zero.
module ebpc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [2:0] wait_input_i,
  output ebpc_pkg::ebpc_claim_type claim_o,
  output logic [2:0] ready_o
);
  import ebpc_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ebpc_apb_req_type req;
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic override_q;
  logic override_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  ebpc_claim_type claim_q;
  ebpc_claim_type claim_d;
  logic [2:0] ready_q;
  logic [2:0] ready_d;
  ebpc_cfg_type cfg;
  ebpc_cfg_type eff;
  logic [2:0] wait_sync;
  logic [2:0] ready_raw;
  logic setup;
  logic hit_cfg;
  logic hit_ctrl;
  logic hit_stat;

  // ----------------------------------------
  // Field view
  // ----------------------------------------
  always_comb begin
    req.psel = psel_i;
    req.penable = penable_i;
    req.pwrite = pwrite_i;
    req.paddr = paddr_i;
    req.pwdata = pwdata_i;
    cfg.ready_invert = cfg_q[`EBPC_RDY_INV_LSB +: 3];
    cfg.ready_pin_claim = cfg_q[`EBPC_RDY_CLAIM_LSB +: 3];
    cfg.ready_level_sense = cfg_q[`EBPC_LEVEL_BIT];
    cfg.reset_powerdown_pin_claim = cfg_q[`EBPC_RP_BIT];
    cfg.write_strobe_pin_claim = cfg_q[`EBPC_WE_BIT];
    cfg.output_strobe_pin_claim = cfg_q[`EBPC_OE_BIT];
    cfg.byte_select_pin_claim = cfg_q[`EBPC_BS_LSB +: 2];
    cfg.chip_select_pin_claim = cfg_q[`EBPC_CS_LSB +: 4];
    cfg.data_pin_claim = cfg_q[`EBPC_DATA_LSB +: 2];
    // Override forces an all-zero view; stored bits are kept for later
    eff = override_q ? '0 : cfg;
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // No wait state: the access phase is answered on its first cycle
  always_comb begin
    setup = req.psel & ~req.penable;
    hit_cfg = (req.paddr == `EBPC_CFG_OFS);
    hit_ctrl = (req.paddr == `EBPC_CTRL_OFS);
    hit_stat = (req.paddr == `EBPC_STAT_OFS);
    cfg_d = cfg_q;
    override_d = override_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (setup) begin
      pready_d = 1'b1;
      pslverr_d = ~(hit_cfg | hit_ctrl | hit_stat) | (hit_stat & req.pwrite);
      prdata_d = 32'h0000_0000;
      if (!req.pwrite) begin
        if (hit_cfg) begin
          prdata_d = cfg_q & `EBPC_CFG_MASK;
        end else if (hit_ctrl) begin
          prdata_d = {31'h0000_0000, override_q};
        end else if (hit_stat) begin
          prdata_d = {18'h0_0000, claim_q};
        end
      end
    end
    // Write lands at the completing edge
    if (req.psel & req.penable & pready_q & req.pwrite) begin
      if (hit_cfg) begin
        cfg_d = req.pwdata & `EBPC_CFG_MASK;
      end else if (hit_ctrl) begin
        override_d = req.pwdata[0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= `EBPC_CFG_RESET;
      override_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      override_q <= override_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------
  // Ready input conditioning
  // ----------------------------------------
  // Synchronisers cost two cycles of latency, unavoidable for raw pins
  generate
    for (genvar i = 0; i < 3; i++) begin : g_rdy
      ebpc_sync2 u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(wait_input_i[i]),
        .sync_o(wait_sync[i])
      );
      ebpc_ready_cond u_cond (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(wait_sync[i]),
        .invert_i(eff.ready_invert[i]),
        .level_i(eff.ready_level_sense),
        .ready_o(ready_raw[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // Pin ownership and outputs
  // ----------------------------------------
  always_comb begin
    claim_d.ready = eff.ready_pin_claim;
    claim_d.reset_powerdown = eff.reset_powerdown_pin_claim;
    claim_d.write_strobe = eff.write_strobe_pin_claim;
    claim_d.output_strobe = eff.output_strobe_pin_claim;
    claim_d.byte_select = eff.byte_select_pin_claim;
    claim_d.chip_select = eff.chip_select_pin_claim;
    claim_d.data = eff.data_pin_claim;
    // Unclaimed ready pins give the bus unit nothing
    ready_d = ready_raw & eff.ready_pin_claim;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      claim_q <= '0;
      ready_q <= 3'h0;
    end else begin
      claim_q <= claim_d;
      ready_q <= ready_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign claim_o = claim_q;
  assign ready_o = ready_q;
endmodule

// ==== test/ebpc_mem_model.sv ====
// Far-side memory devices driving the wait pins.
// Assumes the bench commands each device's level.
`timescale 1ns/1ps
module ebpc_mem_model (
  input wire logic clk_i,
  input wire logic [2:0] want_i,
  output logic [2:0] wait_o
);
  initial wait_o = 3'h0;
  // Devices change only after an edge, as a synchronous part would
  always @(posedge clk_i) begin
    wait_o <= want_i;
  end
endmodule

// ==== test/ebpc_monitor.sv ====
// Port checker for the pin configuration block.
// Assumes binding to ebpc_top; shadows config from completed writes.
`timescale 1ns/1ps
module ebpc_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [2:0] wait_input_i,
  input wire ebpc_pkg::ebpc_claim_type claim_o,
  input wire logic [2:0] ready_o
);
  import ebpc_pkg::*;
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic ovr_q;
  logic ovr_d;
  logic [2:0] qt_q;
  logic [2:0] qt_d;
  logic wr;
  logic [2:0] pol;
  assign wr = psel_i && penable_i && pready_o && pwrite_i;
  assign pol = wait_input_i ^ cfg_q[30:28];
  // Quiet count hides the sync latency after reset and after any config change
  always_comb begin
    cfg_d = (wr && paddr_i == 12'h000) ? pwdata_i : cfg_q;
    ovr_d = (wr && paddr_i == 12'h004) ? pwdata_i[0] : ovr_q;
    qt_d = wr ? 3'h0 : ((qt_q == 3'h7) ? qt_q : qt_q + 3'h1);
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= 32'h0;
      ovr_q <= 1'b0;
      qt_q <= 3'h0;
    end else begin
      cfg_q <= cfg_d;
      ovr_q <= ovr_d;
      qt_q <= qt_d;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rsvd_reads_zero: assert property (
    pready_o && !pwrite_i && paddr_i == 12'h000 |-> (prdata_o & 32'h88fc_cc0c) == 32'h0)
    else $error("reserved bits read nonzero");
  a_override_frees_pins: assert property (
    ovr_q && qt_q > 3'h2 |-> claim_o == '0) else $error("claim under override");
  a_ready_claim_map: assert property (
    !ovr_q && qt_q > 3'h2 |-> claim_o.ready == cfg_q[26:24]) else $error("ready claim");
  a_rp_claim_map: assert property (
    !ovr_q && qt_q > 3'h2 |-> claim_o.reset_powerdown == cfg_q[16]) else $error("rp claim");
  a_other_claim_map: assert property (
    !ovr_q && qt_q > 3'h2 |-> claim_o[9:0] == {cfg_q[13:12], cfg_q[9:4], cfg_q[1:0]})
    else $error("strobe claim");
  a_level_ready: assert property (
    cfg_q[17] && qt_q == 3'h7 |-> ready_o == ($past(pol, 3) & claim_o.ready))
    else $error("level ready");
  a_edge_ready: assert property (
    !cfg_q[17] && qt_q == 3'h7 |-> ready_o == ($past(pol, 3) & ~$past(pol, 4) & claim_o.ready))
    else $error("edge ready");
  c_level: cover property (cfg_q[17] && ready_o[0]);
  c_edge: cover property (!cfg_q[17] && ready_o == 3'h7);
  c_err: cover property (pready_o && pslverr_o);
endmodule
bind ebpc_top ebpc_monitor u_mon (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .wait_input_i(wait_input_i),
  .claim_o(claim_o),
  .ready_o(ready_o)
);

// ==== test/tb.sv ====
// Self-checking bench for the pin configuration block.
// Assumes the memory model stands on the wait pins.
`timescale 1ns/1ps
module tb;
  import ebpc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [2:0] want = 3'h0;
  logic [2:0] wait_input_i;
  ebpc_claim_type claim_o;
  logic [2:0] ready_o;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int n_tests = 0;
  int cnt;
  always #2 clk_i = ~clk_i;
  ebpc_top u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .wait_input_i(wait_input_i),
    .claim_o(claim_o),
    .ready_o(ready_o)
  );
  ebpc_mem_model u_mem (.clk_i(clk_i), .want_i(want), .wait_o(wait_input_i));
  task chk(input logic [31:0] got, input logic [31:0] exp, input string n);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, exp, got);
    end
  endtask
  // One idle cycle between transfers keeps each strobe driven once a step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Look between edges so the answer is read settled, not as it launches
    @(negedge clk_i);
    while (pready_o !== 1'b1) @(negedge clk_i);
    rd = prdata_o;
    err = pslverr_o;
    @(posedge clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task t_regs;
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0, "claim reset");
    apb(1'b1, 12'h000, 32'hffff_ffff);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h7703_33f3, "cfg mask");
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h3fff, "all claimed");
    apb(1'b1, 12'h008, 32'h0);
    chk({31'h0, err}, 32'h1, "status write err");
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    $display("t_regs done");
  endtask
  task t_ovr;
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0, "override claim");
    chk({18'h0, claim_o}, 32'h0, "override pins");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h1, "override readback");
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h7703_33f3, "stored under override");
    apb(1'b1, 12'h004, 32'h0);
    $display("t_ovr done");
  endtask
  task t_level;
    apb(1'b1, 12'h000, 32'h1703_0000);
    for (int p = 0; p < 8; p++) begin
      @(posedge clk_i);
      want <= p[2:0];
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      chk({29'h0, ready_o}, {29'h0, p[2:0] ^ 3'h1}, "level ready");
    end
    chk({31'h0, claim_o.reset_powerdown}, 32'h1, "rp claim");
    $display("t_level done");
  endtask
  // Pulses are counted between edges, where ready_o has settled
  task count_pulses;
    cnt = 0;
    repeat (8) begin
      @(negedge clk_i);
      if (ready_o === 3'h7) cnt++;
    end
  endtask
  task t_free;
    apb(1'b1, 12'h000, 32'h1002_0000);
    want <= 3'h0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk({29'h0, ready_o}, 32'h0, "unclaimed ready");
    chk({29'h0, claim_o.ready}, 32'h0, "ready pins free");
    $display("t_free done");
  endtask
  task t_edge;
    apb(1'b1, 12'h000, 32'h0700_0000);
    want <= 3'h0;
    repeat (6) @(posedge clk_i);
    want <= 3'h7;
    count_pulses;
    chk(cnt, 32'h1, "edge pulses");
    apb(1'b1, 12'h000, 32'h7700_0000);
    repeat (6) @(posedge clk_i);
    want <= 3'h0;
    count_pulses;
    chk(cnt, 32'h1, "inverted edge");
    $display("t_edge done");
  endtask
  task conclude;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_ovr;
    t_level;
    t_free;
    t_edge;
    conclude;
  end
  initial begin
    #20000;
    miscompares++;
    conclude;
  end
endmodule
